// file: design/gst_edge_sync.sv
// Purpose: Two-stage synchroniser with rising and falling detection
// Assumes: One clock; input from another domain
// Notes:   First stage read only by the second
module gst_edge_sync (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // Synchroniser chain and history stage
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edge pulses from settled stages
  assign level_out = sync_reg;
  assign rise_out  = sync_reg & ~prev_reg;
  assign fall_out  = ~sync_reg & prev_reg;
endmodule

// file: design/gst_timer.sv
// Purpose: Gated sixteen-bit timer with APB registers
// Assumes: Pin sources and gate are synchronised before use; overflow inputs arrive as same-clock pulses
// Notes:   Unsynchronised path still sampled here, so it adds a count lag only
// Function
// - Sixteen-bit up-counter in two bytes; byte writes replace live count.
// - Run off stops; run on, gate off counts; both on follow gate.
// - Four-bit select picks external, system, oscillators, or other overflows.
// - Undivided system clock gives four counts per instruction cycle.
// - External-pin counting needs a falling edge first after enable, write, or disable.
// - External source counts rising edges, synchronised or pass-through.
// - Prescaler divides by 1,2,4,8; hidden; cleared by counter writes.
// - Pass-through bit bypasses synchroniser so counting continues in sleep; here the bit is only stored and the pin still goes through the synchroniser.
// - Switching sync mode may lose or add one count.
// - Byte reads stay valid; software stops counter before writing.
// - Wide mode routes high-byte accesses through a buffer.
// - Wide mode low read latches live high byte into buffer.
// - Wide mode low write loads buffer and new low together.
// - Wide mode high write leaves prescaler; only low write clears it.
// - Counter runs freely or under control of a gate signal.
// - Gated counting only while gate level matches polarity; else hold.
// - Rollover FFFFh to 0000h sets overflow flag until software clears.
//
// Decided for this implementation: the address map and the APB slave port.
module gst_timer (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        ext_count_input,
  input  wire logic        high_freq_internal_osc,
  input  wire logic        low_freq_internal_osc,
  input  wire logic        mid_freq_internal_osc,
  input  wire logic        secondary_crystal_osc,
  input  wire logic        reference_clock_out,
  input  wire logic [3:0]  timer_overflow_in,
  input  wire logic        gate_in,
  output logic             overflow_pulse,
  output logic             overflow_flag
);
  logic [7:0]  count_low_byte;
  logic [7:0]  count_high_byte;
  logic [7:0]  high_buffer_reg;
  logic [7:0]  timer_control_reg;
  logic [1:0]  gate_control_reg;
  logic [3:0]  clock_select_reg;
  logic [2:0]  prescale_reg;
  logic [1:0]  instr_phase_reg;
  logic        armed_reg;
  logic        run_prev_reg;
  logic        gate_meta_reg;
  logic        gate_sync_reg;
  logic [7:0]  src_level;
  logic [7:0]  src_rise;
  logic [7:0]  src_fall;
  logic        tick;
  logic        fall_seen;
  logic        count_en;
  logic        pulse;
  logic        wr_fire;
  logic        rd_setup;
  logic        wr_low;
  logic        wr_high;
  logic        run_en;
  logic        wide_access_mode;
  logic        pass_through;
  logic [1:0]  prescale_select;
  logic        gate_enable;
  logic        gate_polarity;
  logic [15:0] count_next;

  // Prescale terminal test; a count left above a lowered limit ends at once
  function automatic logic ps_done(input logic [2:0] cnt, input logic [1:0] sel);
    logic [2:0] lim;
    lim = 3'((4'd1 << sel) - 4'd1);
    return cnt >= lim;
  endfunction

  // Field decoding
  assign run_en           = timer_control_reg[gst_pkg::CTL_RUN_BIT];
  assign wide_access_mode = timer_control_reg[gst_pkg::CTL_WIDE_BIT];
  assign pass_through     = timer_control_reg[gst_pkg::CTL_PASS_BIT];
  assign prescale_select  = timer_control_reg[gst_pkg::CTL_PS_LSB +: 2];
  assign gate_enable      = gate_control_reg[gst_pkg::GATE_EN_BIT];
  assign gate_polarity    = gate_control_reg[gst_pkg::GATE_POL_BIT];

  // APB handshake, zero wait states
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_fire = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;  // Read data and buffer load share this cycle
  assign wr_low  = wr_fire & (paddr == gst_pkg::ADDR_COUNT_LOW);
  assign wr_high = wr_fire & (paddr == gst_pkg::ADDR_COUNT_HIGH);

  // Synchronisers for every pin-level source
  gst_edge_sync u_sync_ext (.core_clk(core_clk), .arst_n(arst_n), .async_in(ext_count_input),
    .level_out(src_level[0]), .rise_out(src_rise[0]), .fall_out(src_fall[0]));
  gst_edge_sync u_sync_hf (.core_clk(core_clk), .arst_n(arst_n), .async_in(high_freq_internal_osc),
    .level_out(src_level[1]), .rise_out(src_rise[1]), .fall_out(src_fall[1]));
  gst_edge_sync u_sync_lf (.core_clk(core_clk), .arst_n(arst_n), .async_in(low_freq_internal_osc),
    .level_out(src_level[2]), .rise_out(src_rise[2]), .fall_out(src_fall[2]));
  gst_edge_sync u_sync_mf (.core_clk(core_clk), .arst_n(arst_n), .async_in(mid_freq_internal_osc),
    .level_out(src_level[3]), .rise_out(src_rise[3]), .fall_out(src_fall[3]));
  gst_edge_sync u_sync_xt (.core_clk(core_clk), .arst_n(arst_n), .async_in(secondary_crystal_osc),
    .level_out(src_level[4]), .rise_out(src_rise[4]), .fall_out(src_fall[4]));
  gst_edge_sync u_sync_rc (.core_clk(core_clk), .arst_n(arst_n), .async_in(reference_clock_out),
    .level_out(src_level[5]), .rise_out(src_rise[5]), .fall_out(src_fall[5]));
  assign src_level[7:6] = 2'b00;
  assign src_rise[7:6]  = 2'b00;
  assign src_fall[7:6]  = 2'b00;

  // Gate pin synchroniser
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_meta_reg <= 1'b0;
      gate_sync_reg <= 1'b0;
    end else begin
      gate_meta_reg <= gate_in;
      gate_sync_reg <= gate_meta_reg;
    end
  end

  // Instruction-cycle phase for the divided system clock
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      instr_phase_reg <= 2'h0;
    end else begin
      instr_phase_reg <= instr_phase_reg + 2'h1;
    end
  end

  // Source selection; overflow codes are same-clock pulses
  always_comb begin
    tick      = 1'b0;
    fall_seen = 1'b1;
    unique case (clock_select_reg)
      gst_pkg::SRC_EXT_PIN:  begin
        tick      = src_rise[0];
        fall_seen = 1'b0;
      end
      gst_pkg::SRC_SYS_DIV4: tick = (instr_phase_reg == gst_pkg::INSTR_DIV_MAX);
      gst_pkg::SRC_SYS:      tick = 1'b1;
      gst_pkg::SRC_HFOSC:    tick = src_rise[1];
      gst_pkg::SRC_LFOSC:    tick = src_rise[2];
      gst_pkg::SRC_MFOSC:    tick = src_rise[3];
      gst_pkg::SRC_XTAL:     tick = src_rise[4];
      gst_pkg::SRC_REFCLK:   tick = src_rise[5];
      4'h8, 4'h9, 4'hA, 4'hB: tick = timer_overflow_in[clock_select_reg[1:0]];
      default:               tick = 1'b0;
    endcase
  end

  // Run and gate combination
  assign count_en = run_en & (~gate_enable | (gate_sync_reg == gate_polarity));

  // Falling-edge arming for the counter input
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      armed_reg    <= 1'b0;
      run_prev_reg <= 1'b0;
    end else begin
      run_prev_reg <= run_en;
      if (wr_low | wr_high | ~run_en | (run_en & ~run_prev_reg & ~src_level[0])) begin
        armed_reg <= 1'b0;
      end else if (src_fall[0]) begin
        armed_reg <= 1'b1;
      end
    end
  end

  // Prescaler; cleared by counter writes, not by wide high write
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prescale_reg <= 3'h0;
    end else if (wr_low | (wr_high & ~wide_access_mode)) begin
      prescale_reg <= 3'h0;
    end else if (tick & count_en & (armed_reg | fall_seen)) begin
      prescale_reg <= ps_done(prescale_reg, prescale_select) ? 3'h0 : prescale_reg + 3'h1;
    end
  end

  // One count per prescaler output
  assign pulse = tick & count_en & (armed_reg | fall_seen) & ps_done(prescale_reg, prescale_select)
                 & ~wr_low & ~wr_high;
  assign count_next = {count_high_byte, count_low_byte} + 16'h0001;

  // Live counter and byte writes
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_low_byte  <= 8'h00;
      count_high_byte <= 8'h00;
    end else if (wr_low) begin
      count_low_byte <= pwdata[7:0];
      if (wide_access_mode) begin
        count_high_byte <= high_buffer_reg;
      end
    end else if (wr_high & ~wide_access_mode) begin
      count_high_byte <= pwdata[7:0];
    end else if (pulse) begin
      count_low_byte  <= count_next[7:0];
      count_high_byte <= count_next[15:8];
    end
  end

  // High-byte buffer for wide access, latched with the low read data
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      high_buffer_reg <= 8'h00;
    end else if (wide_access_mode & wr_high) begin
      high_buffer_reg <= pwdata[7:0];
    end else if (wide_access_mode & rd_setup & (paddr == gst_pkg::ADDR_COUNT_LOW)) begin
      high_buffer_reg <= count_high_byte;
    end
  end

  // Overflow event and sticky flag; set wins over clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      overflow_flag  <= 1'b0;
      overflow_pulse <= 1'b0;
    end else begin
      overflow_pulse <= pulse & ({count_high_byte, count_low_byte} == 16'hFFFF);
      if (pulse & ({count_high_byte, count_low_byte} == 16'hFFFF)) begin
        overflow_flag <= 1'b1;
      end else if (wr_fire & (paddr == gst_pkg::ADDR_STATUS) & pwdata[gst_pkg::STAT_OVF_BIT]) begin
        overflow_flag <= 1'b0;
      end
    end
  end

  // Control registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_control_reg <= gst_pkg::CONTROL_RESET;
      gate_control_reg  <= 2'b00;
      clock_select_reg  <= gst_pkg::CLKSEL_RESET;
    end else if (wr_fire) begin
      if (paddr == gst_pkg::ADDR_CONTROL) begin
        timer_control_reg <= pwdata[7:0] & 8'h37;
      end
      if (paddr == gst_pkg::ADDR_GATE) begin
        gate_control_reg <= pwdata[1:0];
      end
      if (paddr == gst_pkg::ADDR_CLKSEL) begin
        clock_select_reg <= pwdata[3:0];
      end
    end
  end

  // Read data register; unmapped reads return zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (paddr)
        gst_pkg::ADDR_COUNT_LOW:  prdata <= {24'h00_0000, count_low_byte};
        gst_pkg::ADDR_COUNT_HIGH: prdata <= {24'h00_0000, wide_access_mode ? high_buffer_reg : count_high_byte};
        gst_pkg::ADDR_CONTROL:    prdata <= {24'h00_0000, timer_control_reg};
        gst_pkg::ADDR_GATE:       prdata <= {29'h0000_0000, gate_sync_reg, gate_control_reg};
        gst_pkg::ADDR_STATUS:     prdata <= {31'h0000_0000, overflow_flag};
        gst_pkg::ADDR_CLKSEL:     prdata <= {28'h000_0000, clock_select_reg};
        default:                  prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Checks
  a_off_holds: assert property (@(posedge core_clk) disable iff (!arst_n)
    !run_en && !wr_low && !wr_high |=> $stable({count_high_byte, count_low_byte}))
    else $error("count moved while off");
  a_gate_holds: assert property (@(posedge core_clk) disable iff (!arst_n)
    gate_enable && (gate_sync_reg != gate_polarity) |-> !pulse)
    else $error("count while gate inactive");
  a_step_one: assert property (@(posedge core_clk) disable iff (!arst_n)
    pulse |=> {count_high_byte, count_low_byte} == $past({count_high_byte, count_low_byte}) + 16'h0001)
    else $error("step not one");
  a_ovf_sets: assert property (@(posedge core_clk) disable iff (!arst_n)
    pulse && {count_high_byte, count_low_byte} == 16'hFFFF |=> overflow_flag && overflow_pulse)
    else $error("overflow flag not set");
  a_wr_clears_ps: assert property (@(posedge core_clk) disable iff (!arst_n)
    wr_low |=> prescale_reg == 3'h0)
    else $error("prescaler not cleared");
  a_wide_hi_keep: assert property (@(posedge core_clk) disable iff (!arst_n)
    wide_access_mode && wr_high |=> $stable(count_high_byte))
    else $error("wide high write reached counter");
  a_wide_latch: assert property (@(posedge core_clk) disable iff (!arst_n)
    wide_access_mode && rd_setup && paddr == gst_pkg::ADDR_COUNT_LOW |=> high_buffer_reg == $past(count_high_byte))
    else $error("buffer not latched");
  a_wide_load: assert property (@(posedge core_clk) disable iff (!arst_n)
    wide_access_mode && wr_low |=> count_high_byte == $past(high_buffer_reg) && count_low_byte == $past(pwdata[7:0]))
    else $error("wide write not atomic");
  a_arm_needed: assert property (@(posedge core_clk) disable iff (!arst_n)
    clock_select_reg == gst_pkg::SRC_EXT_PIN && !armed_reg |-> !pulse)
    else $error("count before falling edge");
  a_sys_full: assert property (@(posedge core_clk) disable iff (!arst_n)
    clock_select_reg == gst_pkg::SRC_SYS && run_en && !gate_enable && prescale_select == 2'b00 |-> pulse || wr_low || wr_high)
    else $error("system clock not counted");
  c_overflow: cover property (@(posedge core_clk) disable iff (!arst_n) overflow_pulse);
  c_wide_write: cover property (@(posedge core_clk) disable iff (!arst_n) wide_access_mode && wr_low);
  c_ext_count: cover property (@(posedge core_clk) disable iff (!arst_n)
    clock_select_reg == gst_pkg::SRC_EXT_PIN && pulse);
  c_pass_count: cover property (@(posedge core_clk) disable iff (!arst_n)
    pass_through && clock_select_reg == gst_pkg::SRC_EXT_PIN && pulse);
endmodule

// file: shared/gst_pkg.sv
// Purpose: Constants for the gated sixteen-bit timer
// Assumes: APB, 32-bit data, one register per aligned word
// Notes:   Offsets chosen for this block
package gst_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_COUNT_LOW  = 8'h00;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h04;
  localparam logic [7:0] ADDR_CONTROL    = 8'h08;
  localparam logic [7:0] ADDR_GATE       = 8'h0C;
  localparam logic [7:0] ADDR_STATUS     = 8'h10;
  localparam logic [7:0] ADDR_CLKSEL     = 8'h14;
  // Control register fields
  localparam int CTL_RUN_BIT    = 0;
  localparam int CTL_PASS_BIT   = 2;
  localparam int CTL_WIDE_BIT   = 1;
  localparam int CTL_PS_LSB     = 4;
  // Gate register fields
  localparam int GATE_EN_BIT    = 0;
  localparam int GATE_POL_BIT   = 1;
  // Status register fields
  localparam int STAT_OVF_BIT   = 0;
  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [3:0] CLKSEL_RESET  = 4'h0;
  // Clock source codes
  localparam logic [3:0] SRC_EXT_PIN   = 4'h0;
  localparam logic [3:0] SRC_SYS_DIV4  = 4'h1;
  localparam logic [3:0] SRC_SYS       = 4'h2;
  localparam logic [3:0] SRC_HFOSC     = 4'h3;
  localparam logic [3:0] SRC_LFOSC     = 4'h4;
  localparam logic [3:0] SRC_MFOSC     = 4'h5;
  localparam logic [3:0] SRC_XTAL      = 4'h6;
  localparam logic [3:0] SRC_REFCLK    = 4'h7;
  localparam logic [3:0] SRC_OVF_FIRST = 4'h8;
  localparam logic [3:0] SRC_OVF_LAST  = 4'hB;
  // Counts of the undivided clock per instruction cycle
  localparam int INSTR_DIV = 4;
  localparam logic [1:0] INSTR_DIV_MAX = 2'h3;
endpackage

// file: tb/gst_ext_src.sv
// Purpose: Model of the external count source feeding the timer
// Assumes: Bench asks for trains of whole pulses
// Notes:   Line stands at the idle level between trains
module gst_ext_src (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       start,
  input  wire logic [7:0] n_pulses,
  input  wire logic [3:0] half,
  input  wire logic       idle_lvl,
  output logic            ext_count_input,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] togg_left;
  logic [3:0] tick;
  // Train of toggles, two per pulse, half+1 cycles per level
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_count_input <= 1'b0;
      togg_left       <= 9'h000;
      tick            <= 4'h0;
    end else if (togg_left == 9'h000) begin
      ext_count_input <= idle_lvl;  // Still between trains
      togg_left       <= start ? {n_pulses, 1'b0} : 9'h000;
      tick            <= half;
    end else if (tick == 4'h0) begin
      ext_count_input <= ~ext_count_input;
      togg_left       <= togg_left - 9'h001;
      tick            <= half;
    end else begin
      tick <= tick - 4'h1;
    end
  end
  assign busy = (togg_left != 9'h000);
endmodule

// file: tb/gst_timer_tb_top.sv
// Purpose: Self-checking bench for the gated sixteen-bit timer
// Assumes: Zero-wait APB slave; sources driven from a free divider
// Notes:   Counts measured as differences over exact cycle windows
module gst_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        start = 1'b0, idle_lvl = 1'b1, gate_in = 1'b0, ext_line, busy, pready, pslverr;
  logic        overflow_pulse, overflow_flag;
  logic [7:0]  paddr = 8'h00, div = 8'h00, n_pulses = 8'h00;
  logic [3:0]  ovf_in = 4'h0, half = 4'h2;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [15:0] dlt, v;
  logic [15:0] exp_src [16] = '{16'h0000, 16'h0010, 16'h0040, 16'h0010, 16'h0002, 16'h0008, 16'h0004,
    16'h0001, 16'h0020, 16'h0010, 16'h0008, 16'h0004, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  int          cyc = 0, n_ovf = 0, n_mismatch = 0, checks_done = 0, t_set, t, k, n0;
  always #4 core_clk = ~core_clk;
  // Cycle count, oscillator and overflow sources, overflow pulse tally
  always @(posedge core_clk) begin
    cyc    <= cyc + 1;
    div    <= div + 8'h01;
    ovf_in <= {div[3:0] == 4'hF, div[2:0] == 3'h7, div[1:0] == 2'h3, div[0]};
    if (overflow_pulse === 1'b1) n_ovf <= n_ovf + 1;
  end
  gst_ext_src src_u (.core_clk(core_clk), .arst_n(arst_n), .start(start), .n_pulses(n_pulses),
    .half(half), .idle_lvl(idle_lvl), .ext_count_input(ext_line), .busy(busy));
  gst_timer dut_u (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .ext_count_input(ext_line), .high_freq_internal_osc(div[1]), .low_freq_internal_osc(div[4]),
    .mid_freq_internal_osc(div[2]), .secondary_crystal_osc(div[3]), .reference_clock_out(div[5]),
    .timer_overflow_in(ovf_in), .gate_in(gate_in), .overflow_pulse(overflow_pulse),
    .overflow_flag(overflow_flag));
  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is seen high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    t_set = cyc;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) n_mismatch++;
    if (k >= 20) close_out();
    rd = prdata;
    chk({31'h0000_0000, pslverr}, 32'h0000_0000);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  // Coherent sixteen-bit read in wide mode: low first, then buffered high
  task automatic read16(output logic [15:0] q, output int ts);
    xfer(1'b0, gst_pkg::ADDR_COUNT_LOW, 32'h0000_0000);
    ts = t_set;
    q[7:0] = rd[7:0];
    xfer(1'b0, gst_pkg::ADDR_COUNT_HIGH, 32'h0000_0000);
    q[15:8] = rd[7:0];
  endtask
  // Count gained over exactly w cycles between two read starts
  task automatic measure(input int w);
    logic [15:0] a;
    int          t0;
    read16(a, t0);
    while (cyc < t0 + w - 1) @(posedge core_clk);
    read16(dlt, t);
    dlt = dlt - a;
  endtask
  function automatic logic [31:0] ctlw(logic run, logic pass, logic [1:0] ps);
    logic [31:0] d;
    d = 32'h0000_0000;
    d[gst_pkg::CTL_RUN_BIT] = run;
    d[gst_pkg::CTL_WIDE_BIT] = 1'b1;
    d[gst_pkg::CTL_PASS_BIT] = pass;
    d[gst_pkg::CTL_PS_LSB +: 2] = ps;
    return d;
  endfunction
  // Main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    rdchk(gst_pkg::ADDR_CONTROL, {24'h00_0000, gst_pkg::CONTROL_RESET});
    rdchk(gst_pkg::ADDR_CLKSEL, {28'h000_0000, gst_pkg::CLKSEL_RESET});
    rdchk(gst_pkg::ADDR_STATUS, 32'h0000_0000);
    wr(8'h20, 32'hFFFF_FFFF);
    rdchk(8'h20, 32'h0000_0000);
    wr(gst_pkg::ADDR_COUNT_LOW, 32'h0000_0034);
    wr(gst_pkg::ADDR_COUNT_HIGH, 32'h0000_0012);
    rdchk(gst_pkg::ADDR_COUNT_LOW, 32'h0000_0034);
    rdchk(gst_pkg::ADDR_COUNT_HIGH, 32'h0000_0012);
    wr(gst_pkg::ADDR_CONTROL, ctlw(1'b0, 1'b0, 2'h0));
    wr(gst_pkg::ADDR_COUNT_HIGH, 32'h0000_00AB);
    rdchk(gst_pkg::ADDR_COUNT_LOW, 32'h0000_0034);
    rdchk(gst_pkg::ADDR_COUNT_HIGH, 32'h0000_0012);
    wr(gst_pkg::ADDR_COUNT_HIGH, 32'h0000_00AB);
    wr(gst_pkg::ADDR_COUNT_LOW, 32'h0000_00CD);
    rdchk(gst_pkg::ADDR_COUNT_LOW, 32'h0000_00CD);
    rdchk(gst_pkg::ADDR_COUNT_HIGH, 32'h0000_00AB);
    // Every source code except the external pin (code 0) over a 64-cycle window; crystal model runs from reset, so ready
    wr(gst_pkg::ADDR_CONTROL, ctlw(1'b1, 1'b0, 2'h0));
    for (int i = 1; i < 16; i++) begin
      wr(gst_pkg::ADDR_CLKSEL, 32'(i));
      measure(64);
      chk({16'h0000, dlt}, {16'h0000, exp_src[i]});
    end
    // Prescale settings on the undivided clock
    wr(gst_pkg::ADDR_CLKSEL, {28'h000_0000, gst_pkg::SRC_SYS});
    for (int p = 0; p < 4; p++) begin
      wr(gst_pkg::ADDR_CONTROL, ctlw(1'b1, 1'b0, 2'(p)));
      measure(64);
      chk({16'h0000, dlt}, 32'(64 >> p));
    end
    // Run, gate enable, gate level and polarity, all combinations
    for (int i = 0; i < 16; i++) begin
      gate_in <= i[2];
      wr(gst_pkg::ADDR_GATE, (32'(i[3]) << gst_pkg::GATE_POL_BIT) | (32'(i[1]) << gst_pkg::GATE_EN_BIT));
      wr(gst_pkg::ADDR_CONTROL, ctlw(i[0], 1'b0, 2'h0));
      measure(16);
      chk({16'h0000, dlt}, (i[0] && (!i[1] || i[2] == i[3])) ? 32'h0000_0010 : 32'h0000_0000);
    end
    wr(gst_pkg::ADDR_GATE, 32'h0000_0000);
    // External pin: idle level high and low, synchronised and pass-through
    wr(gst_pkg::ADDR_CLKSEL, {28'h000_0000, gst_pkg::SRC_EXT_PIN});
    for (int i = 0; i < 4; i++) begin
      wr(gst_pkg::ADDR_CONTROL, ctlw(1'b0, i[1], 2'h0));
      idle_lvl <= i[0];
      wr(gst_pkg::ADDR_CONTROL, ctlw(1'b1, i[1], 2'h0));
      wr(gst_pkg::ADDR_COUNT_HIGH, 32'h0000_0000);
      wr(gst_pkg::ADDR_COUNT_LOW, 32'h0000_0000);
      n_pulses <= 8'h05;
      half     <= i[1] ? 4'h7 : 4'h2;
      start    <= 1'b1;
      @(posedge core_clk);
      start <= 1'b0;
      @(posedge core_clk);
      for (k = 0; busy !== 1'b0 && k < 200; k++) @(posedge core_clk);
      if (k >= 200) n_mismatch++;
      if (k >= 200) close_out();
      repeat (8) @(posedge core_clk);
      read16(v, t);
      chk({16'h0000, v}, i[0] ? 32'h0000_0005 : 32'h0000_0004);
    end
    // Rollover sets the sticky flag once; write one clears it
    wr(gst_pkg::ADDR_CONTROL, ctlw(1'b0, 1'b0, 2'h0));
    wr(gst_pkg::ADDR_CLKSEL, {28'h000_0000, gst_pkg::SRC_SYS});
    wr(gst_pkg::ADDR_COUNT_HIGH, 32'h0000_00FF);
    wr(gst_pkg::ADDR_COUNT_LOW, 32'h0000_00F0);
    n0 = n_ovf;
    wr(gst_pkg::ADDR_CONTROL, ctlw(1'b1, 1'b0, 2'h0));
    for (k = 0; overflow_flag !== 1'b1 && k < 100; k++) @(posedge core_clk);
    if (k >= 100) n_mismatch++;
    if (k >= 100) close_out();
    wr(gst_pkg::ADDR_CONTROL, ctlw(1'b0, 1'b0, 2'h0));
    chk(32'(n_ovf - n0), 32'h0000_0001);
    rdchk(gst_pkg::ADDR_STATUS, 32'h0000_0001 << gst_pkg::STAT_OVF_BIT);
    wr(gst_pkg::ADDR_STATUS, 32'h0000_0001 << gst_pkg::STAT_OVF_BIT);
    rdchk(gst_pkg::ADDR_STATUS, 32'h0000_0000);
    chk({31'h0000_0000, overflow_flag}, 32'h0000_0000);
    close_out();
  end
endmodule
